// [design/fpi_pkg.sv]
package fpi_pkg;

  // option register location and field positions
  localparam logic [7:0]  FPI_OPT_ADDR      = 8'hC8;
  localparam logic [7:0]  FPI_OPT_RESET     = 8'h00;
  localparam int          FPI_LES_BIT       = 6;
  localparam int          FPI_ESB_BIT       = 5;
  localparam int          FPI_GEN_BIT       = 4;
  // extra registers for event flags, masks and status
  localparam logic [7:0]  FPI_EVT_FLAG_ADDR = 8'hCC;
  localparam logic [7:0]  FPI_EVT_MASK_ADDR = 8'hCD;
  localparam logic [7:0]  FPI_PIN_MASK_ADDR = 8'hCE;
  localparam logic [7:0]  FPI_STATUS_ADDR   = 8'hCF;
  localparam logic [7:0]  FPI_MASK_RESET    = 8'h00;
  localparam logic [7:0]  FPI_READ_ZERO     = 8'h00;

  // vector locations in program space, one per source
  localparam logic [11:0] FPI_VEC_SRC0      = 12'hFFC;
  localparam logic [11:0] FPI_VEC_SRC1      = 12'hFF6;
  localparam logic [11:0] FPI_VEC_SRC2      = 12'hFF4;
  localparam logic [11:0] FPI_VEC_SRC3      = 12'hFF2;
  localparam logic [11:0] FPI_VEC_SRC4      = 12'hFF0;

  // immediate load timing behind the entry defect
  localparam logic [1:0]  FPI_LDI_RACE_CYC  = 2'h3;
  localparam logic [2:0]  FPI_LDI_LEN_CYC   = 3'h4;

  // flag pair indices
  localparam logic [1:0]  FPI_PAIR_NORMAL   = 2'h0;
  localparam logic [1:0]  FPI_PAIR_INT      = 2'h1;
  localparam logic [1:0]  FPI_PAIR_NMI      = 2'h2;

  // core mode, one-hot
  typedef enum logic [2:0] {
    FPI_MODE_NORMAL = 3'b001,
    FPI_MODE_INT    = 3'b010,
    FPI_MODE_NMI    = 3'b100
  } fpi_mode_type;

  // peripheral event flags, same order as their mask bits
  typedef struct packed {
    logic tmr_ovf;
    logic adc_eoc;
    logic uart_rx;
    logic uart_tx;
    logic ar_ovf;
    logic ar_cmp;
    logic ar_edge;
    logic spi_end;
  } fpi_evt_type;

  // core sequencer to interrupt unit
  typedef struct packed {
    logic        instr_end;
    logic        return_from_interrupt;
    logic        low_power;
    logic        ldi_opt_zero;
    logic        flag_wr;
    logic        carry;
    logic        zero;
    logic [11:0] pc;
  } fpi_core_in_type;

  // interrupt unit to core sequencer
  typedef struct packed {
    logic         take;
    logic [11:0]  vector;
    logic         ret;
    logic [11:0]  ret_pc;
    logic         carry;
    logic         zero;
    logic         wake;
    fpi_mode_type mode;
  } fpi_core_out_type;

endpackage : fpi_pkg

// [design/fpi_unit.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module fpi_unit
  import fpi_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_in,
  // register port
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic [7:0]                reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic [7:0]                     reg_rdata_out,
  // request side: peripherals and port pins
  input  wire fpi_pkg::fpi_evt_type      evt_in,
  input  wire logic [3:0]                port_pin_in,
  // servicing side: core sequencer
  input  wire fpi_pkg::fpi_core_in_type  core_in,
  output fpi_pkg::fpi_core_out_type      core_out
);
  import fpi_pkg::*;

  // pin order inside port_pin_in
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;

  // highest pending maskable source, 0 when none
  function automatic logic [2:0] pick_src(input logic [4:1] pend);
    if (pend[1])      pick_src = 3'h1;
    else if (pend[2]) pick_src = 3'h2;
    else if (pend[3]) pick_src = 3'h3;
    else if (pend[4]) pick_src = 3'h4;
    else              pick_src = 3'h0;
  endfunction : pick_src

  // vector location of a source
  function automatic logic [11:0] src_vec(input logic [2:0] src);
    case (src)
      3'h1:    src_vec = FPI_VEC_SRC1;
      3'h2:    src_vec = FPI_VEC_SRC2;
      3'h3:    src_vec = FPI_VEC_SRC3;
      3'h4:    src_vec = FPI_VEC_SRC4;
      default: src_vec = FPI_VEC_SRC0;
    endcase
  endfunction : src_vec

  logic [2:0]       opt_reg;          // les, esb, gen
  logic [7:0]       evt_mask_reg;     // one mask per peripheral event
  logic [3:0]       pin_mask_reg;     // one mask per port pin
  logic [3:0]       sync1_reg;        // pin synchroniser stage 1
  logic [3:0]       sync2_reg;        // stage 2
  logic [3:0]       sync3_reg;        // stage 3
  logic [3:0]       pin_reg;          // filtered pin level
  logic             line1_reg;        // previous source 1 request level
  logic             line2_reg;        // previous source 2 line level
  logic             lat_nmi_reg;      // nmi flip-flop
  logic             lat1_reg;         // source 1 edge latch
  logic             lat2_reg;         // source 2 edge latch
  fpi_mode_type     mode_reg;         // current core mode
  fpi_mode_type     nmi_ret_mode_reg; // mode to resume after nmi
  logic [1:0]       nmi_ret_sel_reg;  // flag pair to resume after nmi
  logic [1:0]       sel_reg;          // flag pair in use
  logic [1:0]       pair_reg [3];     // carry/zero pairs
  logic [11:0]      stack_reg [2];    // pc save, second slot for nmi over int
  logic [1:0]       depth_reg;        // stack slots in use
  logic [2:0]       ldi_cnt_reg;      // cycle inside the option clear load
  logic             race_reg;         // request seen early in that load
  fpi_core_out_type core_out_reg;     // registered answer to the core
  logic [7:0]       rdata_reg;        // read data, one cycle after strobe

  logic             gen;
  logic             source1_level_select;
  logic             source2_edge_polarity;
  logic             act1;
  logic             line2;
  logic             act3;
  logic             act4;
  logic             nmi_set;
  logic             set1;
  logic             set2;
  logic [4:1]       pend;
  logic [2:0]       src_sel;
  logic             acc_nmi;
  logic             acc_mask;

  assign gen = opt_reg[0];
  assign source2_edge_polarity = opt_reg[1];
  assign source1_level_select = opt_reg[2];

  // pins cross in through three flops, filtered on agreement
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
      if (rst_in)
      begin
        sync1_reg[i] <= 1'b1;
        sync2_reg[i] <= 1'b1;
        sync3_reg[i] <= 1'b1;
        pin_reg[i]   <= 1'b1;
      end
      else
      begin
        sync1_reg[i] <= port_pin_in[i];
        sync2_reg[i] <= sync1_reg[i];
        sync3_reg[i] <= sync2_reg[i];
        // only a level seen twice counts
        if (sync2_reg[i] == sync3_reg[i])
          pin_reg[i] <= sync3_reg[i];
      end
    end
  end

  // request lines built from masked events; active low pins
  assign act1  = (evt_in.spi_end & evt_mask_reg[0]) |
                 (~pin_reg[PIN_A] & pin_mask_reg[PIN_A]);
  assign line2 = ~((~pin_reg[PIN_B] & pin_mask_reg[PIN_B]) |
                   (~pin_reg[PIN_D] & pin_mask_reg[PIN_D]));
  assign act3  = |(evt_mask_reg[3:1] &
                   {evt_in.ar_ovf, evt_in.ar_cmp, evt_in.ar_edge});
  assign act4  = |(evt_mask_reg[7:4] & {evt_in.tmr_ovf, evt_in.adc_eoc,
                   evt_in.uart_rx, evt_in.uart_tx});

  // edge detection for nmi and sources 1 and 2
  assign nmi_set = ~pin_reg[PIN_C] & sync3_reg[PIN_C] & (sync2_reg[PIN_C] == sync3_reg[PIN_C])
                   ? 1'b0 : (pin_reg[PIN_C] & ~sync3_reg[PIN_C] &
                   (sync2_reg[PIN_C] == sync3_reg[PIN_C]) & pin_mask_reg[PIN_C]);
  assign set1 = ~source1_level_select & act1 & ~line1_reg;
  assign set2 = source2_edge_polarity ? (line2 & ~line2_reg) : (~line2 & line2_reg);

  // pending requests; level sources sampled as they stand
  assign pend[1] = gen & (source1_level_select ? act1 : lat1_reg);
  assign pend[2] = gen & lat2_reg;
  assign pend[3] = gen & act3;
  assign pend[4] = gen & act4;
  assign src_sel = pick_src(pend);

  // arbitration at instruction end only
  assign acc_nmi  = core_in.instr_end & lat_nmi_reg &
                    (mode_reg != FPI_MODE_NMI);
  assign acc_mask = core_in.instr_end & ~acc_nmi & (src_sel != 3'h0) &
                    (mode_reg == FPI_MODE_NORMAL);

  // register writes; option register keeps only its used bits
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      opt_reg      <= FPI_OPT_RESET[FPI_LES_BIT:FPI_GEN_BIT];
      evt_mask_reg <= FPI_MASK_RESET;
      pin_mask_reg <= FPI_MASK_RESET[3:0];
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        FPI_OPT_ADDR:      opt_reg <= reg_wdata_in[FPI_LES_BIT:FPI_GEN_BIT];
        FPI_EVT_MASK_ADDR: evt_mask_reg <= reg_wdata_in;
        FPI_PIN_MASK_ADDR: pin_mask_reg <= reg_wdata_in[3:0];
        default:           ;                                 // other writes ignored
      endcase
    end
  end

  // reads; option register is write-only and reads zero
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_reg <= FPI_READ_ZERO;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        FPI_EVT_FLAG_ADDR: rdata_reg <= evt_in;
        FPI_EVT_MASK_ADDR: rdata_reg <= evt_mask_reg;
        FPI_PIN_MASK_ADDR: rdata_reg <= {4'h0, pin_mask_reg};
        FPI_STATUS_ADDR:   rdata_reg <= {mode_reg, lat_nmi_reg, lat1_reg,
                                         lat2_reg, depth_reg};
        default:           rdata_reg <= FPI_READ_ZERO;
      endcase
    end
    else
      rdata_reg <= FPI_READ_ZERO;
  end

  // request latches; a new edge wins over the clear at entry
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      line1_reg   <= 1'b0;
      line2_reg   <= 1'b1;
      lat_nmi_reg <= 1'b0;
      lat1_reg    <= 1'b0;
      lat2_reg    <= 1'b0;
    end
    else
    begin
      line1_reg <= act1;
      line2_reg <= line2;
      if (nmi_set)
        lat_nmi_reg <= 1'b1;
      else if (acc_nmi)
        lat_nmi_reg <= 1'b0;
      // level mode stores nothing
      if (source1_level_select)
        lat1_reg <= 1'b0;
      else if (set1)
        lat1_reg <= 1'b1;
      else if (acc_mask && src_sel == 3'h1)
        lat1_reg <= 1'b0;
      if (set2)
        lat2_reg <= 1'b1;
      else if (acc_mask && src_sel == 3'h2)
        lat2_reg <= 1'b0;
    end
  end

  // watch the 4-cycle option clear for an early request
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ldi_cnt_reg <= 3'h0;
      race_reg    <= 1'b0;
    end
    else
    begin
      if (core_in.ldi_opt_zero && ldi_cnt_reg != FPI_LDI_LEN_CYC)
        ldi_cnt_reg <= ldi_cnt_reg + 3'h1;
      else if (!core_in.ldi_opt_zero)
        ldi_cnt_reg <= 3'h0;
      // armed only by a request in the first three cycles
      if (core_in.ldi_opt_zero && ldi_cnt_reg < {1'b0, FPI_LDI_RACE_CYC} &&
          src_sel != 3'h0 && mode_reg == FPI_MODE_NORMAL)
        race_reg <= 1'b1;
      else if (core_in.instr_end && !core_in.ldi_opt_zero)
        race_reg <= 1'b0;
    end
  end

  // mode, flag pair select and pc stack on entry and return
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_reg         <= FPI_MODE_NORMAL;
      nmi_ret_mode_reg <= FPI_MODE_NORMAL;
      nmi_ret_sel_reg  <= FPI_PAIR_NORMAL;
      sel_reg          <= FPI_PAIR_NORMAL;
      depth_reg        <= 2'h0;
      stack_reg[0]     <= 12'h000;
      stack_reg[1]     <= 12'h000;
    end
    else if (acc_nmi)
    begin
      // nmi may land on top of a maskable routine
      nmi_ret_mode_reg            <= mode_reg;
      nmi_ret_sel_reg             <= sel_reg;
      mode_reg                    <= FPI_MODE_NMI;
      sel_reg                     <= FPI_PAIR_NMI;
      stack_reg[depth_reg[0]]     <= core_in.pc;
      depth_reg                   <= depth_reg + 2'h1;
    end
    else if (acc_mask)
    begin
      mode_reg                    <= FPI_MODE_INT;
      // race leaves the normal pair in use
      sel_reg                     <= race_reg ? FPI_PAIR_NORMAL : FPI_PAIR_INT;
      stack_reg[depth_reg[0]]     <= core_in.pc;
      depth_reg                   <= depth_reg + 2'h1;
    end
    else if (core_in.return_from_interrupt && depth_reg != 2'h0)
    begin
      depth_reg <= depth_reg - 2'h1;
      if (mode_reg == FPI_MODE_NMI)
      begin
        mode_reg <= nmi_ret_mode_reg;
        sel_reg  <= nmi_ret_sel_reg;
      end
      else
      begin
        mode_reg <= FPI_MODE_NORMAL;
        sel_reg  <= FPI_PAIR_NORMAL;
      end
    end
  end

  // flag pairs; core writes into the selected pair only
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pair_reg[0] <= 2'h0;
      pair_reg[1] <= 2'h0;
      pair_reg[2] <= 2'h0;
    end
    else if (core_in.flag_wr)
      pair_reg[sel_reg] <= {core_in.carry, core_in.zero};
  end

  // answer to core; take and ret are one-cycle pulses
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      core_out_reg        <= '0;
      core_out_reg.mode   <= FPI_MODE_NORMAL;
      core_out_reg.vector <= FPI_VEC_SRC0;
    end
    else
    begin
      core_out_reg.take <= acc_nmi | acc_mask;
      if (acc_nmi)
        core_out_reg.vector <= FPI_VEC_SRC0;
      else if (acc_mask)
        core_out_reg.vector <= src_vec(src_sel);
      core_out_reg.ret <= core_in.return_from_interrupt && depth_reg != 2'h0 && !acc_nmi && !acc_mask;
      core_out_reg.ret_pc <= stack_reg[depth_reg[1]];
      core_out_reg.carry  <= pair_reg[sel_reg][1];
      core_out_reg.zero   <= pair_reg[sel_reg][0];
      core_out_reg.mode   <= mode_reg;
      // wake only with global enable, even for nmi
      core_out_reg.wake   <= core_in.low_power & gen &
                             (lat_nmi_reg | (src_sel != 3'h0));
    end
  end

  assign core_out      = core_out_reg;
  assign reg_rdata_out = rdata_reg;

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  AST_NMI_FIRST: assert property (acc_nmi |=> core_out.take && core_out.vector == FPI_VEC_SRC0)
    else $error("nmi accept did not give nmi vector");
  AST_VEC_MAP: assert property (acc_mask && src_sel == 3'h4 |=> core_out.vector == FPI_VEC_SRC4)
    else $error("source 4 vector wrong");
  AST_TAKE_PULSE: assert property ($rose(core_out.take) |=> !core_out.take || $past(acc_nmi | acc_mask))
    else $error("take stood without an accept");
  AST_NO_NEST: assert property (mode_reg == FPI_MODE_INT && core_in.instr_end && !lat_nmi_reg |=> !core_out.take)
    else $error("maskable nested into maskable routine");
  AST_PRIO: assert property (acc_mask && pend[1] |=> core_out.vector == FPI_VEC_SRC1)
    else $error("source 1 not served first");
  AST_GEN_OFF: assert property (!gen && !lat_nmi_reg && core_in.instr_end |=> !core_out.take)
    else $error("masked source taken with enable low");
  AST_WAKE_GATE: assert property (!gen |=> !core_out.wake)
    else $error("wake raised with enable low");
  AST_NMI_CLEAR: assert property (acc_nmi && !nmi_set |=> !lat_nmi_reg)
    else $error("nmi latch not cleared on entry");
  AST_EDGE_HOLD: assert property (lat1_reg && !source1_level_select && !(acc_mask && src_sel == 3'h1) |=> lat1_reg)
    else $error("source 1 latch lost");
  AST_FLAG_SWAP: assert property (acc_mask && !race_reg ##1
    (!core_in.return_from_interrupt && !acc_nmi) [*2] |-> sel_reg == FPI_PAIR_INT)
    else $error("interrupt flag pair not selected");
  AST_RETURN_FROM_INTERRUPT: assert property (core_in.return_from_interrupt && mode_reg == FPI_MODE_INT && !acc_nmi |=>
    mode_reg == FPI_MODE_NORMAL ##1 core_out.mode == FPI_MODE_NORMAL)
    else $error("return did not restore normal mode");

  COV_NMI_OVER_INT: cover property (mode_reg == FPI_MODE_INT ##1 acc_nmi);
  COV_RACE: cover property (race_reg && acc_mask);
  COV_SRC2_EDGE: cover property (set2 ##[1:20] acc_mask && src_sel == 3'h2);
  COV_WAKE: cover property (core_out.wake);

endmodule : fpi_unit

// [sim/fpi_core_model.sv]
`timescale 1ns/1ps
module fpi_core_model
  import fpi_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_in,
  // bench controls
  input  wire logic                      run_in,
  input  wire logic                      ldi_in,
  input  wire logic                      return_from_interrupt_in,
  input  wire logic                      low_power_in,
  input  wire logic                      flag_wr_in,
  input  wire logic [1:0]                flag_in,
  // unit side
  input  wire fpi_pkg::fpi_core_out_type core_out_in,
  output fpi_pkg::fpi_core_in_type       core_in_out
);
  logic [1:0]  cyc_reg; // position inside a four-cycle instruction
  logic [11:0] pc_reg;  // program counter of the modelled core
  logic        end_w;   // last cycle of an instruction

  // a stopped core never ends an instruction, so no request is accepted
  assign end_w = run_in && (cyc_reg == 2'h3);

  // sequencing and program counter
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cyc_reg <= 2'h0;
      pc_reg  <= 12'h100;
    end
    else
    begin
      if (run_in)
        cyc_reg <= cyc_reg + 2'h1;
      if (core_out_in.take)
        pc_reg <= core_out_in.vector;
      else if (core_out_in.ret)
        pc_reg <= core_out_in.ret_pc;
      else if (end_w)
        pc_reg <= pc_reg + 12'h1;
    end
  end

  // return only at an instruction end; option clear load set by the bench
  assign core_in_out.instr_end    = end_w;
  assign core_in_out.return_from_interrupt         = end_w && return_from_interrupt_in;
  assign core_in_out.low_power    = low_power_in;
  assign core_in_out.ldi_opt_zero = ldi_in;
  assign core_in_out.flag_wr      = flag_wr_in;
  assign core_in_out.carry        = flag_in[1];
  assign core_in_out.zero         = flag_in[0];
  assign core_in_out.pc           = pc_reg;
endmodule : fpi_core_model

// [sim/fixed_priority_interrupt_unit_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  $display("[FAIL] %s exp=%0h got=%0h", nm, ex, gt); error_cnt++; end end
module fixed_priority_interrupt_unit_tb;
  import fpi_pkg::*;
  logic             clk_sys_in = 1'b0;   // 40 MHz system clock
  logic             rst_in     = 1'b1;   // async reset
  logic [7:0]       reg_addr   = 8'h00;  // register port
  logic [7:0]       reg_wdata  = 8'h00;
  logic             reg_wr     = 1'b0;
  logic             reg_rd     = 1'b0;
  logic [7:0]       reg_rdata;
  fpi_evt_type      evt        = '0;     // peripheral events
  logic [3:0]       pins       = 4'hF;   // pins idle high, low requests
  logic             run        = 1'b0;   // core executing
  logic             return_from_interrupt_req   = 1'b0;
  logic             lp         = 1'b0;   // core in stop or wait
  logic             ldi        = 1'b0;   // core inside the option clear load
  logic             fwr        = 1'b0;
  logic [1:0]       flg        = 2'h0;   // carry, zero to write
  fpi_core_in_type  core_in;
  fpi_core_out_type core_out;
  logic [11:0]      last_pc    = 12'h000; // pc seen at last instruction end
  logic [11:0]      sv_pc      = 12'h000; // pc expected back on return
  logic [11:0]      int_pc     = 12'h000; // pc the routine under an nmi returns to
  logic [7:0]       st;                   // last read data
  int               error_cnt  = 0;
  int               compares   = 0;
  int               cyc        = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  fpi_unit dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .evt_in(evt), .port_pin_in(pins),
    .core_in(core_in), .core_out(core_out));

  fpi_core_model core_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .run_in(run), .ldi_in(ldi),
    .return_from_interrupt_in(return_from_interrupt_req), .low_power_in(lp), .flag_wr_in(fwr), .flag_in(flg),
    .core_out_in(core_out), .core_in_out(core_in));

  // remember the pc the unit must push
  always @(posedge clk_sys_in)
    if (core_in.instr_end)
      last_pc <= core_in.pc;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      results();
    end
  end

  task results;
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd   <= 1'b0;
    @(negedge clk_sys_in);
    st = reg_rdata;
  endtask : rd

  task wait_take(input logic [11:0] v, input fpi_mode_type md);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    while (core_out.take !== 1'b1 && n < 60)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK("take", 1'b1, core_out.take)
    `CHK("vector", v, core_out.vector)
    sv_pc = last_pc;
    @(negedge clk_sys_in);
    `CHK("mode", md, core_out.mode)
  endtask : wait_take

  task no_take(input int n);
    repeat (n)
    begin
      @(negedge clk_sys_in);
      `CHK("no take", 1'b0, core_out.take)
    end
  endtask : no_take

  // hold the return request until the unit answers
  task do_return_from_interrupt;
    int n;
    n = 0;
    @(posedge clk_sys_in);
    return_from_interrupt_req <= 1'b1;
    @(negedge clk_sys_in);
    while (core_out.ret !== 1'b1 && n < 60)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK("ret", 1'b1, core_out.ret)
    `CHK("ret pc", sv_pc, core_out.ret_pc)
    @(posedge clk_sys_in);
    return_from_interrupt_req <= 1'b0;
  endtask : do_return_from_interrupt

  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    `CHK("rst vector", FPI_VEC_SRC0, core_out.vector)
    `CHK("rst mode", FPI_MODE_NORMAL, core_out.mode)
    rd(FPI_OPT_ADDR);
    `CHK("opt read", 8'h00, st)
    wr(FPI_OPT_ADDR, 8'hFF);
    rd(FPI_OPT_ADDR);
    `CHK("opt write only", 8'h00, st)
    rd(8'h55);
    `CHK("unmapped", 8'h00, st)
    // three levels pending at once: fixed order 1, 3, 4
    wr(FPI_OPT_ADDR, 8'h50);
    wr(FPI_EVT_MASK_ADDR, 8'hFF);
    wr(FPI_PIN_MASK_ADDR, 8'h0F);
    @(posedge clk_sys_in);
    fwr <= 1'b1;
    flg <= 2'h2;
    @(posedge clk_sys_in);
    fwr <= 1'b0;
    evt <= fpi_evt_type'(8'h85);
    run <= 1'b1;
    wait_take(FPI_VEC_SRC1, FPI_MODE_INT);
    `CHK("int carry", 1'b0, core_out.carry)
    `CHK("int zero", 1'b0, core_out.zero)
    no_take(24);
    @(posedge clk_sys_in);
    evt <= fpi_evt_type'(8'h84);
    do_return_from_interrupt();
    wait_take(FPI_VEC_SRC3, FPI_MODE_INT);
    @(posedge clk_sys_in);
    evt <= fpi_evt_type'(8'h80);
    do_return_from_interrupt();
    wait_take(FPI_VEC_SRC4, FPI_MODE_INT);
    @(posedge clk_sys_in);
    evt <= '0;
    do_return_from_interrupt();
    repeat (2) @(negedge clk_sys_in);
    `CHK("back carry", 1'b1, core_out.carry)
    `CHK("back mode", FPI_MODE_NORMAL, core_out.mode)
    // request during the option clear load keeps the normal pair
    @(posedge clk_sys_in);
    run <= 1'b0;
    evt <= fpi_evt_type'(8'h08);
    ldi <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    ldi <= 1'b0;
    run <= 1'b1;
    wait_take(FPI_VEC_SRC3, FPI_MODE_INT);
    `CHK("race carry", 1'b1, core_out.carry)
    // nmi lands on top of the running routine
    int_pc = sv_pc;
    @(posedge clk_sys_in);
    pins <= 4'hB;
    wait_take(FPI_VEC_SRC0, FPI_MODE_NMI);
    @(posedge clk_sys_in);
    pins <= 4'hF;
    evt  <= '0;
    do_return_from_interrupt();
    repeat (2) @(negedge clk_sys_in);
    `CHK("back to int", FPI_MODE_INT, core_out.mode)
    sv_pc = int_pc;
    do_return_from_interrupt();
    // enable off: maskable blocked, nmi kept but cannot wake
    wr(FPI_OPT_ADDR, 8'h00);
    @(posedge clk_sys_in);
    evt <= fpi_evt_type'(8'h08);
    no_take(24);
    rd(FPI_EVT_FLAG_ADDR);
    `CHK("evt flags", 8'h08, st)
    @(posedge clk_sys_in);
    run  <= 1'b0;
    lp   <= 1'b1;
    pins <= 4'hB;
    repeat (8) @(posedge clk_sys_in);
    rd(FPI_STATUS_ADDR);
    `CHK("nmi latched", 8'h30, st)
    `CHK("no wake", 1'b0, core_out.wake)
    wr(FPI_OPT_ADDR, 8'h10);
    repeat (3) @(negedge clk_sys_in);
    `CHK("wake", 1'b1, core_out.wake)
    wr(FPI_OPT_ADDR, 8'h00);
    @(posedge clk_sys_in);
    lp  <= 1'b0;
    run <= 1'b1;
    wait_take(FPI_VEC_SRC0, FPI_MODE_NMI);
    rd(FPI_STATUS_ADDR);
    `CHK("nmi cleared", 8'h81, st)
    @(posedge clk_sys_in);
    pins <= 4'hF;
    evt  <= '0;
    do_return_from_interrupt();
    no_take(16);
    // edge versus level, two pulses per line before service
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk_sys_in);
      run <= 1'b0;
      wr(FPI_OPT_ADDR, (m == 1) ? 8'h70 : 8'h10);
      @(posedge clk_sys_in);
      pins <= 4'hC;
      repeat (8) @(posedge clk_sys_in);
      rd(FPI_STATUS_ADDR);
      `CHK("src1 on fall", m == 0, st[3])
      `CHK("src2 on fall", m == 0, st[2])
      @(posedge clk_sys_in);
      pins <= 4'hF;
      repeat (8) @(posedge clk_sys_in);
      rd(FPI_STATUS_ADDR);
      `CHK("src1 stored", m == 0, st[3])
      `CHK("src2 stored", 1'b1, st[2])
      @(posedge clk_sys_in);
      pins <= 4'hC;
      repeat (8) @(posedge clk_sys_in);
      pins <= 4'hF;
      repeat (8) @(posedge clk_sys_in);
      run <= 1'b1;
      if (m == 0)
      begin
        wait_take(FPI_VEC_SRC1, FPI_MODE_INT);
        do_return_from_interrupt();
      end
      wait_take(FPI_VEC_SRC2, FPI_MODE_INT);
      do_return_from_interrupt();
      no_take(24);
    end
    results();
  end
endmodule : fixed_priority_interrupt_unit_tb
